// ===== core/adcsbc_top.sv
// adcsbc_top: second converter control register and sequencing control
// assumes the converter core pulses seq_done_i once per finished sequence
// and sample_start_i once per sample, both on clk_i
// and that software reads results only from the half not being filled;
// bus ready outputs are flops, so each channel idles one cycle after reset
//
// Operation
// R1: reference field 000/1xx supply-ground, 001 external high, 010 external low, 011 both
// R2: offset calibration ties both hold inputs to low reference, else selectors steer
// R3: scan bit enables stepping through scan-selected inputs
// R4: interrupt after every (N+1)th sample/convert sequence
// R5: split bit gives two eight-word halves, else one sixteen-word buffer
// R6: fill-status reads 1 while filling upper half, 0 for lower
// R7: software reads only the half not being filled
// R8: alternate bit uses setting A first then B, A, ...; clear means A
// R9: unimplemented bits read zero, all reset zero, fill-status read-only
// R10: fill-status toggles at each interrupt group completion in split mode
//
// Chosen here: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ns
module adcsbc_top
   import adcsbc_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        seq_done_i,
   input  wire logic        sample_start_i,
   output logic             ref_high_ext_o,
   output logic             ref_low_ext_o,
   output logic             hold_to_low_ref_o,
   output logic             input_scan_enable_o,
   output logic             result_buffer_split_o,
   output logic [3:0]       result_word_base_o,
   output logic             mux_setting_b_o,
   output logic             seq_irq_o,
   output logic             irq_o
);

   // map reference field code to routing
   function automatic adcsbc_ref_t ref_decode(input logic [2:0] code);
      if (code[2]) begin
         ref_decode = ADCSBC_REF_SUPPLY;
      end else begin
         ref_decode = adcsbc_ref_t'(code[1:0]);
      end
   endfunction

   // byte-enable merge used by the control register
   function automatic logic [31:0] strb_merge(input logic [31:0] old,
                                              input logic [31:0] data,
                                              input logic [3:0]  strb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[i*8 +: 8] = data[i*8 +: 8];
         end
      end
      strb_merge = res;
   endfunction

   // true for the four register offsets; others answer with an error
   function automatic logic addr_mapped(input logic [7:0] addr);
      addr_mapped = (addr == ADDR_CTRL2) || (addr == ADDR_IRQ_STAT) ||
                    (addr == ADDR_IRQ_MASK) || (addr == ADDR_STATE);
   endfunction

   logic [31:0]        ctrl_ff;
   logic               half_ff;
   logic [3:0]         seq_cnt_ff;
   logic               alt_b_ff;
   logic [NUM_EVT-1:0] stat_ff;
   logic [NUM_EVT-1:0] mask_ff;
   logic               aw_hold_ff;
   logic [7:0]         aw_addr_ff;
   logic               w_hold_ff;
   logic [31:0]        w_data_ff;
   logic [3:0]         w_strb_ff;
   logic               bvalid_ff;
   logic [1:0]         bresp_ff;
   logic               rvalid_ff;
   logic [31:0]        rdata_ff;
   logic [1:0]         rresp_ff;
   logic               seq_irq_ff;
   logic               irq_ff;
   logic [5:0]         out_ff;
   logic [3:0]         base_ff;
   logic               aw_ready_ff;
   logic               w_ready_ff;
   logic               ar_ready_ff;

   logic               wr_fire;
   logic               group_done;
   logic [3:0]         spi_n;
   logic [NUM_EVT-1:0] evt;
   logic [NUM_EVT-1:0] clr;
   adcsbc_ref_t        ref_sel;
   logic               wr_ctrl;
   logic               wr_stat;
   logic               wr_mask;
   logic [31:0]        rd_word;
   logic [1:0]         rd_resp;

   // sequence and event decode
   assign spi_n      = ctrl_ff[SPI_HI:SPI_LO];
   assign wr_fire    = aw_hold_ff && w_hold_ff && !bvalid_ff;
   assign group_done = seq_done_i && (seq_cnt_ff == spi_n); // R4
   assign ref_sel    = ref_decode(ctrl_ff[REF_HI:REF_LO]);   // R1
   assign evt[EVT_GROUP] = group_done;
   assign evt[EVT_SWAP]  = group_done && ctrl_ff[SPLIT_BIT];
   // one strobe per writable register, high only in the cycle a write completes
   assign wr_ctrl = wr_fire && (aw_addr_ff == ADDR_CTRL2);
   assign wr_stat = wr_fire && (aw_addr_ff == ADDR_IRQ_STAT) && w_strb_ff[0];
   assign wr_mask = wr_fire && (aw_addr_ff == ADDR_IRQ_MASK) && w_strb_ff[0];
   assign clr     = wr_stat ? w_data_ff[NUM_EVT-1:0] : '0;

   // write address and data are taken independently; ready is a flop,
   // low while the channel holds an item that is not yet answered
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         aw_hold_ff  <= 1'b0;
         aw_ready_ff <= 1'b0;
         aw_addr_ff  <= 8'h00;
      end else if (s_axi_awvalid && aw_ready_ff) begin
         aw_hold_ff  <= 1'b1;
         aw_ready_ff <= 1'b0;
         aw_addr_ff  <= s_axi_awaddr;
      end else if (wr_fire) begin
         aw_hold_ff  <= 1'b0;
         aw_ready_ff <= 1'b1;
      end else begin
         aw_ready_ff <= !aw_hold_ff;
      end
   end

   // write data channel, same scheme as the address channel
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         w_hold_ff  <= 1'b0;
         w_ready_ff <= 1'b0;
         w_data_ff  <= RESET_ZERO;
         w_strb_ff  <= 4'h0;
      end else if (s_axi_wvalid && w_ready_ff) begin
         w_hold_ff  <= 1'b1;
         w_ready_ff <= 1'b0;
         w_data_ff  <= s_axi_wdata;
         w_strb_ff  <= s_axi_wstrb;
      end else if (wr_fire) begin
         w_hold_ff  <= 1'b0;
         w_ready_ff <= 1'b1;
      end else begin
         w_ready_ff <= !w_hold_ff;
      end
   end

   // ready outputs come straight from their flops
   assign s_axi_awready = aw_ready_ff;
   assign s_axi_wready  = w_ready_ff;

   // write response, error on unmapped address
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bvalid_ff <= 1'b0;
         bresp_ff  <= RESP_OKAY;
      end else if (wr_fire) begin
         bvalid_ff <= 1'b1;
         bresp_ff  <= addr_mapped(aw_addr_ff) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         bvalid_ff <= 1'b0;
      end
   end

   // control register; only implemented writable bits stored
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_ff <= RESET_ZERO; // R9
      end else if (wr_ctrl) begin
         ctrl_ff <= strb_merge(ctrl_ff, w_data_ff, w_strb_ff) & CTRL2_WR_MASK; // R9
      end
   end

   // mask register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mask_ff <= '0;
      end else if (wr_mask) begin
         mask_ff <= w_data_ff[NUM_EVT-1:0];
      end
   end

   // sticky status, set wins over write-one-to-clear
   generate
      for (genvar g = 0; g < NUM_EVT; g++) begin : g_stat
         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               stat_ff[g] <= 1'b0;
            end else if (evt[g]) begin
               stat_ff[g] <= 1'b1;
            end else if (clr[g]) begin
               stat_ff[g] <= 1'b0;
            end
         end
      end
   endgenerate

   // sequence counter wraps after N+1 sequences
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         seq_cnt_ff <= 4'h0;
      end else if (group_done) begin
         seq_cnt_ff <= 4'h0; // R4
      end else if (seq_done_i) begin
         seq_cnt_ff <= seq_cnt_ff + 4'h1;
      end
   end

   // fill half: toggles per group in split mode, lower half otherwise
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         half_ff <= 1'b0;
      end else if (!ctrl_ff[SPLIT_BIT]) begin
         half_ff <= 1'b0; // R5
      end else if (group_done) begin
         half_ff <= !half_ff; // R10
      end
   end

   // mux alternation: A first, then B, A, ...
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         alt_b_ff <= 1'b0;
      end else if (!ctrl_ff[ALT_BIT]) begin
         alt_b_ff <= 1'b0; // R8
      end else if (sample_start_i) begin
         alt_b_ff <= !alt_b_ff; // R8
      end
   end

   // registered outputs toward the converter core
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         out_ff  <= 6'h00;
         base_ff <= 4'h0;
      end else begin
         out_ff[0] <= (ref_sel == ADCSBC_REF_EXT_HI) || (ref_sel == ADCSBC_REF_EXT_BOTH); // R1
         out_ff[1] <= (ref_sel == ADCSBC_REF_EXT_LO) || (ref_sel == ADCSBC_REF_EXT_BOTH); // R1
         out_ff[2] <= ctrl_ff[OFFSET_CALIBRATION_ENABLE_BIT]; // R2
         out_ff[3] <= ctrl_ff[SCAN_BIT];   // R3
         out_ff[4] <= ctrl_ff[SPLIT_BIT];  // R5
         out_ff[5] <= alt_b_ff;            // R8
         base_ff   <= {half_ff, 3'h0};     // R6
      end
   end

   // converter-side outputs straight from their flops
   assign ref_high_ext_o        = out_ff[0];
   assign ref_low_ext_o         = out_ff[1];
   assign hold_to_low_ref_o     = out_ff[2];
   assign input_scan_enable_o   = out_ff[3];
   assign result_buffer_split_o = out_ff[4];
   assign mux_setting_b_o       = out_ff[5];
   assign result_word_base_o    = base_ff;

   // interrupt outputs
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         seq_irq_ff <= 1'b0;
         irq_ff     <= 1'b0;
      end else begin
         seq_irq_ff <= group_done; // R4
         irq_ff     <= |(stat_ff & mask_ff);
      end
   end

   // interrupt outputs straight from their flops
   assign seq_irq_o = seq_irq_ff;
   assign irq_o     = irq_ff;

   // read data for the offered address; unmapped offsets return zero
   always_comb begin
      rd_word = RESET_ZERO;
      case (s_axi_araddr)
         ADDR_CTRL2: begin
            rd_word = ctrl_ff | ({31'h0, half_ff} << HALF_BIT); // R6 R9
         end
         ADDR_IRQ_STAT: begin
            rd_word = {{(32-NUM_EVT){1'b0}}, stat_ff};
         end
         ADDR_IRQ_MASK: begin
            rd_word = {{(32-NUM_EVT){1'b0}}, mask_ff};
         end
         ADDR_STATE: begin
            rd_word = {26'h0, alt_b_ff, half_ff, seq_cnt_ff};
         end
         default: begin
            rd_word = RESET_ZERO; // R9
         end
      endcase
   end

   assign rd_resp = addr_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;

   // read channel, one read at a time; arready stays low while rvalid stands
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rvalid_ff   <= 1'b0;
         ar_ready_ff <= 1'b0;
         rdata_ff    <= RESET_ZERO;
         rresp_ff    <= RESP_OKAY;
      end else if (s_axi_arvalid && ar_ready_ff) begin
         rvalid_ff   <= 1'b1;
         ar_ready_ff <= 1'b0;
         rdata_ff    <= rd_word;
         rresp_ff    <= rd_resp;
      end else begin
         if (s_axi_rready) begin
            rvalid_ff <= 1'b0;
         end
         ar_ready_ff <= !rvalid_ff || s_axi_rready;
      end
   end

   // bus answer outputs straight from their flops
   assign s_axi_arready = ar_ready_ff;
   assign s_axi_rvalid  = rvalid_ff;
   assign s_axi_rdata   = rdata_ff;
   assign s_axi_rresp   = rresp_ff;
   assign s_axi_bvalid  = bvalid_ff;
   assign s_axi_bresp   = bresp_ff;

endmodule

// ===== core/adcsbc_pkg.sv
// adcsbc_pkg: constants for the converter control block
// assumes a 32-bit AXI4-Lite register bus, byte addressed
package adcsbc_pkg;
   localparam logic [7:0]  ADDR_CTRL2     = 8'h00; // converter_control_two
   localparam logic [7:0]  ADDR_IRQ_STAT  = 8'h04; // sticky event status
   localparam logic [7:0]  ADDR_IRQ_MASK  = 8'h08; // event mask
   localparam logic [7:0]  ADDR_STATE     = 8'h0C; // live state readback
   localparam logic [31:0] CTRL2_WR_MASK  = 32'h0000_F43F; // writable bits
   localparam logic [31:0] RESET_ZERO     = 32'h0000_0000;
   localparam int REF_HI = 15;
   localparam int REF_LO = 13;
   localparam int OFFSET_CALIBRATION_ENABLE_BIT = 12;
   localparam int SCAN_BIT = 10;
   localparam int HALF_BIT = 7;
   localparam int SPI_HI = 5;
   localparam int SPI_LO = 2;
   localparam int SPLIT_BIT = 1;
   localparam int ALT_BIT = 0;
   localparam int NUM_EVT = 2;     // 0: group done, 1: half swapped
   localparam int EVT_GROUP = 0;
   localparam int EVT_SWAP = 1;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef enum logic [1:0] {
      ADCSBC_REF_SUPPLY = 2'h0, // analog_supply / analog_ground
      ADCSBC_REF_EXT_HI = 2'h1,
      ADCSBC_REF_EXT_LO = 2'h2,
      ADCSBC_REF_EXT_BOTH = 2'h3
   } adcsbc_ref_t;
endpackage

// ===== dv/adcsbc_monitor.sv
// adcsbc_monitor: port assertions for adcsbc_top
// assumes one clock domain with a synchronous reset
`timescale 1ns/1ns
module adcsbc_monitor (
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_rvalid,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        seq_done_i,
   input wire logic        sample_start_i,
   input wire logic        ref_high_ext_o,
   input wire logic        ref_low_ext_o,
   input wire logic        hold_to_low_ref_o,
   input wire logic        input_scan_enable_o,
   input wire logic        result_buffer_split_o,
   input wire logic [3:0]  result_word_base_o,
   input wire logic        mux_setting_b_o,
   input wire logic        seq_irq_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic [2:0] wr_age_ff;
   logic [4:0] cfg;
   assign cfg = {ref_high_ext_o, ref_low_ext_o, hold_to_low_ref_o, input_scan_enable_o,
                 result_buffer_split_o};
   // cycles since the bus last offered a write, saturating
   always_ff @(posedge clk_i) begin
      if (rst_i || s_axi_awvalid || s_axi_wvalid) wr_age_ff <= 3'h0;
      else if (wr_age_ff != 3'h7) wr_age_ff <= wr_age_ff + 3'h1;
   end
   chk_cfg_on_write: assert property ($changed(cfg) |-> wr_age_ff < 3'h4)
      else $error("config output moved without a write");
   chk_irq_single: assert property (seq_irq_o |=> !seq_irq_o)
      else $error("group interrupt wider than one cycle");
   chk_irq_cause: assert property (seq_irq_o |-> $past(seq_done_i))
      else $error("group interrupt without a finished sequence");
   chk_base_value: assert property (result_word_base_o inside {4'h0, 4'h8})
      else $error("fill base is not a half boundary");
   chk_base_unsplit: assert property (
      !result_buffer_split_o && !$past(result_buffer_split_o) |-> result_word_base_o == 4'h0)
      else $error("upper half used while unsplit");
   // the base output moves one cycle after the group pulse
   chk_half_swap: assert property (
      result_buffer_split_o && $past(result_buffer_split_o) && $changed(result_word_base_o)
      |-> $past(seq_irq_o))
      else $error("half swapped outside a group end");
   // setting b shows two cycles after the sample pulse that toggles it
   chk_mux_cause: assert property ($rose(mux_setting_b_o) |-> $past(sample_start_i, 2))
      else $error("setting b taken without a sample");
   chk_rd_zero: assert property (s_axi_rvalid |-> (s_axi_rdata & 32'hFFFF_0B40) == 32'h0)
      else $error("unimplemented bits read nonzero");
   cov_irq: cover property (seq_irq_o);
   cov_upper: cover property (result_word_base_o == 4'h8);
   cov_mux_b: cover property (mux_setting_b_o);
endmodule
bind adcsbc_top adcsbc_monitor mon (.clk_i, .rst_i, .s_axi_awvalid, .s_axi_wvalid,
   .s_axi_rvalid, .s_axi_rdata, .seq_done_i, .sample_start_i, .ref_high_ext_o,
   .ref_low_ext_o, .hold_to_low_ref_o, .input_scan_enable_o, .result_buffer_split_o,
   .result_word_base_o, .mux_setting_b_o, .seq_irq_o);

// ===== dv/adcsbc_core_model.sv
// adcsbc_core_model: converter core giving sample and sequence pulses
// assumes gap_i of at least 2 and run_i from the bench
`timescale 1ns/1ns
module adcsbc_core_model (
   input  wire logic       clk_i,
   input  wire logic       run_i,
   input  wire logic [3:0] gap_i,
   output logic            start_o,
   output logic            done_o
);
   logic [3:0] cnt_ff;
   // one sample opens each sequence, done closes it gap_i - 1 cycles on
   always_ff @(posedge clk_i) begin
      start_o <= run_i && cnt_ff == 4'h1;
      done_o <= run_i && cnt_ff == gap_i;
      if (!run_i || cnt_ff == gap_i) cnt_ff <= 4'h0;
      else cnt_ff <= cnt_ff + 4'h1;
   end
endmodule

// ===== dv/adcsbc_top_tb.sv
// adcsbc_top_tb: self-checking bench for adcsbc_top
// assumes the core model and monitor are compiled first
`timescale 1ns/1ns
module adcsbc_top_tb;
   import adcsbc_pkg::*;
   logic        clk_i = 0, rst_i = 1, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0, run = 0;
   logic [7:0]  awa = 0, ara = 0;
   logic [31:0] wd = 0, rdat;
   logic [3:0]  gap = 4'h2, base;
   logic [1:0]  bresp, rresp;
   logic        awr, wrd, bv, arr, rv, ss, sd, rh, rl, hl, se, sp, mb, si, irq;
   int          seed = 32'hb9ff, mismatches = 0, checks = 0, irqs, smp;
   adcsbc_top dut (.clk_i, .rst_i, .s_axi_awaddr(awa), .s_axi_awvalid(awv),
      .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
      .s_axi_wready(wrd), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(bre),
      .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
      .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rre), .seq_done_i(sd),
      .sample_start_i(ss), .ref_high_ext_o(rh), .ref_low_ext_o(rl), .hold_to_low_ref_o(hl),
      .input_scan_enable_o(se), .result_buffer_split_o(sp), .result_word_base_o(base),
      .mux_setting_b_o(mb), .seq_irq_o(si), .irq_o(irq));
   adcsbc_core_model core (.clk_i, .run_i(run), .gap_i(gap), .start_o(ss), .done_o(sd));
   initial begin
      forever #2 clk_i = ~clk_i;
   end
   // count pulses the core and block give
   always @(posedge clk_i) begin
      if (si === 1'b1) irqs++;
      if (ss === 1'b1) smp++;
   end
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      int n;
      n = 0;
      @(posedge clk_i);
      awa <= a; wd <= d; awv <= 1; wv <= 1; bre <= 1;
      do begin
         @(posedge clk_i);
         n++;
         if (awr) awv <= 0;
         if (wrd) wv <= 0;
      end while (!bv && n < 64);
      bre <= 0; r = bresp;
      if (!bv) begin mismatches++; tally_and_finish(); end
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      n = 0;
      @(posedge clk_i);
      ara <= a; arv <= 1; rre <= 1;
      do begin
         @(posedge clk_i);
         n++;
         if (arr) arv <= 0;
      end while (!rv && n < 64);
      rre <= 0; d = rdat; r = rresp;
      if (!rv) begin mismatches++; tally_and_finish(); end
   endtask
   function automatic logic [1:0] exp_ref(input logic [2:0] c);
      return {c == 3'h1 || c == 3'h3, c == 3'h2 || c == 3'h3};
   endfunction
   initial begin
      logic [31:0] d, q;
      logic [1:0] r;
      logic hf, mx;
      int sm, k, c;
      repeat (6) @(posedge clk_i);
      rst_i <= 0;
      // unmapped write, then reset values and the unmapped read
      wr(8'h10, 32'hFFFF_FFFF, r);
      chk("unmapped wresp", RESP_SLVERR, r);
      for (int i = 0; i < 5; i++) begin
         rd(8'(i * 4), q, r);
         chk("reset read", 32'h0, q);
         chk("read resp", (i == 4) ? RESP_SLVERR : RESP_OKAY, r);
      end
      $display("test reset done");
      // every reference code with random neighbours, then all ones
      for (int i = 0; i < 9; i++) begin
         d = (i == 8) ? 32'hFFFF_FFFF : ({$random(seed)} & 32'hFFFF_1FFF) | (32'(i) << 13);
         wr(ADDR_CTRL2, d, r);
         rd(ADDR_CTRL2, q, r);
         chk("ctrl readback", d & CTRL2_WR_MASK, q);
         chk("reference", exp_ref(d[15:13]), {rh, rl});
         chk("hold", d[OFFSET_CALIBRATION_ENABLE_BIT], hl);
         chk("scan", d[SCAN_BIT], se);
         chk("split", d[SPLIT_BIT], sp);
      end
      $display("test config done");
      // three groups per mode: N of 0, 15 and random
      hf = 0; mx = 0;
      wr(ADDR_IRQ_MASK, 32'h1, r);
      for (int j = 0; j < 3; j++) begin
         sm = (j == 0) ? 0 : (j == 1) ? 15 : {$random(seed)} % 15;
         wr(ADDR_CTRL2, {26'h0, 4'(sm), 1'(j != 2), 1'(j != 1)}, r);
         wr(ADDR_IRQ_STAT, 32'h3, r);
         irqs = 0; smp = 0; k = 0; c = 0;
         gap <= 4'(2 + {$random(seed)} % 6);
         run <= 1;
         while (k < 3 * (sm + 1) && c < 3000) begin
            @(posedge clk_i);
            c++;
            if (sd) k++;
         end
         run <= 0;
         if (c >= 3000) begin mismatches++; tally_and_finish(); end
         repeat (4) @(posedge clk_i);
         hf = (j != 2) ? !hf : 1'b0;
         mx = (j != 1) ? mx ^ smp[0] : 1'b0;
         chk("group irqs", 3, irqs);
         chk("fill base", hf ? 32'h8 : 32'h0, base);
         chk("mux b", mx, mb);
         rd(ADDR_STATE, q, r);
         chk("state", {26'h0, mx, hf, 4'h0}, q);
         rd(ADDR_CTRL2, q, r);
         chk("fill status", hf, q[HALF_BIT]);
         chk("read half", hf ? 32'h0 : 32'h8, {28'h0, base ^ 4'h8});
         rd(ADDR_IRQ_STAT, q, r);
         chk("status", {30'h0, 1'(j != 2), 1'b1}, q);
         chk("irq raised", 1, irq);
         wr(ADDR_IRQ_STAT, 32'h1, r);
         repeat (2) @(posedge clk_i);
         chk("irq cleared", 0, irq);
         $display("test group %0d done", j);
      end
      tally_and_finish();
   end
endmodule
